// >>> line_modem_regs.svh
`ifndef LINE_MODEM_REGS_SVH
`define LINE_MODEM_REGS_SVH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_ERRCNT 8'h08

// control fields
`define CTRL_CLKSEL_LSB 0
`define CTRL_CLKSEL_MSB 1
`define CTRL_RATE_LSB 2
`define CTRL_RATE_MSB 4
`define CTRL_HALF_DUPLEX 5
`define CTRL_PATTERN 6
`define CTRL_BLINK 7
`define CTRL_CTS_LONG 8
`define CTRL_CARRIER_OPT 9
`define CTRL_CD_HIGH 10
`define CTRL_PANEL_EN 11
`define CTRL_ANALOG_EN 12
`define CTRL_REMOTE_EN 13
`define CTRL_SEQ_DELAY 14
`define CTRL_MASK 32'h0000_7fff
`define CTRL_RESET 32'h0000_7e00

// status fields
`define STAT_ERR 0
`define STAT_SYNC 1
`define STAT_ANALOG 2
`define STAT_DIGITAL 3
`define STAT_REMOTE 4
`define STAT_PATTERN 5
`define STAT_CTS 6
`define STAT_CD 7
`define STAT_CARRIER 8

// timing
`define CLK_KHZ 40000
`define CTS_SHORT_MS 8
`define CTS_LONG_MS 70
`define BLINK_MS 250
`define SYNC_GOOD 5'h10
`define PRBS_SEED 9'h1ff
`define PRBS_TAP_A 8
`define PRBS_TAP_B 4
`define NCO_W 24

// selectable rates in kbps by select code
`define RATE_0 144
`define RATE_1 128
`define RATE_2 112
`define RATE_3 96
`define RATE_4 72
`define RATE_5 64
`define RATE_6 56
`define RATE_7 48
`endif

// >>> modem_pkg.sv
package modem_pkg;
    typedef enum logic [1:0] {
        CLK_INTERNAL = 2'h0,
        CLK_TERMINAL = 2'h1,
        CLK_RECOVERED = 2'h2
    } tx_clk_src_e;

    typedef enum logic [2:0] {
        CTS_OFF = 3'h1,
        CTS_WAIT = 3'h2,
        CTS_ON = 3'h4
    } cts_state_e;
endpackage

// >>> prbs9_link.sv
`timescale 1ns/1ps
`include "line_modem_regs.svh"
module prbs9_link (
    // link clock and system reset
    input wire logic link_clk,
    input wire logic aresetn,
    // levels from the register domain
    input wire logic pattern_on,
    input wire logic analog_on,
    input wire logic digital_on,
    input wire logic seq_delay_on,
    // serial data
    input wire logic terminal_tx_data,
    input wire logic line_rx_data,
    output logic line_tx_data,
    output logic terminal_rx_data,
    // status back to the register domain
    output logic err_toggle,
    output logic in_sync
);
    logic [1:0] rst_meta_reg, rst_next;
    logic [3:0] c_meta_reg, c_sync_reg;
    logic [8:0] gen_reg, gen_next, chk_reg, chk_next;
    logic [4:0] good_reg, good_next;
    logic tx_reg, tx_next, trx_reg, trx_next, tog_reg, tog_next, sync_reg, sync_next;
    logic link_rstn, pat_s, ana_s, dig_s, dly_s, fb, rx_bit, predicted;

    assign link_rstn = rst_meta_reg[1];
    assign {dly_s, dig_s, ana_s, pat_s} = c_sync_reg;
    assign fb = gen_reg[`PRBS_TAP_A] ^ gen_reg[`PRBS_TAP_B];
    assign predicted = chk_reg[`PRBS_TAP_A] ^ chk_reg[`PRBS_TAP_B];

    always_comb begin
        rst_next = {rst_meta_reg[0], aresetn};
        gen_next = {gen_reg[7:0], fb};
        tx_next = pat_s ? fb : (dig_s ? line_rx_data : terminal_tx_data);
        // analog loop returns our own line output, so the checker sees it
        rx_bit = ana_s ? tx_reg : line_rx_data;
        chk_next = {chk_reg[7:0], rx_bit};
        good_next = good_reg;
        sync_next = sync_reg;
        tog_next = tog_reg;
        if (!pat_s) begin
            good_next = 5'h00;
            sync_next = 1'b0;
        end else if (rx_bit != predicted) begin
            good_next = 5'h00;
            if (sync_reg) begin
                tog_next = ~tog_reg;
            end
        end else if (!sync_reg) begin
            good_next = good_reg + 5'h01;
            sync_next = (good_reg + 5'h01) == `SYNC_GOOD;
        end
        // hold mark toward the terminal so a loop sequence is not relayed
        trx_next = (dly_s && (dig_s || ana_s)) ? 1'b1 : rx_bit;
    end

    always_ff @(posedge link_clk) begin
        rst_meta_reg <= rst_next;
        c_meta_reg <= {seq_delay_on, digital_on, analog_on, pattern_on};
        c_sync_reg <= c_meta_reg;
        if (!link_rstn) begin
            gen_reg <= `PRBS_SEED;
            chk_reg <= 9'h000;
            good_reg <= 5'h00;
            sync_reg <= 1'b0;
            tog_reg <= 1'b0;
            tx_reg <= 1'b1;
            trx_reg <= 1'b1;
        end else begin
            gen_reg <= gen_next;
            chk_reg <= chk_next;
            good_reg <= good_next;
            sync_reg <= sync_next;
            tog_reg <= tog_next;
            tx_reg <= tx_next;
            trx_reg <= trx_next;
        end
    end

    assign line_tx_data = tx_reg;
    assign terminal_rx_data = trx_reg;
    assign err_toggle = tog_reg;
    assign in_sync = sync_reg;

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!link_rstn);

    a_pattern_tx_bit: assert property (pat_s |=> tx_reg == $past(fb))
        else $error("pattern bit not sent");
    a_error_in_sync: assert property ($changed(tog_reg) |-> $past(sync_reg && pat_s))
        else $error("error counted before sync");
    a_seq_block_mark: assert property ((dly_s && dig_s) |=> trx_reg)
        else $error("loop sequence relayed");
endmodule

// >>> line_modem_core.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "line_modem_regs.svh"
module line_modem_core
    import modem_pkg::*;
#(
    parameter int CTS_SHORT_CYC = `CTS_SHORT_MS * `CLK_KHZ,
    parameter int CTS_LONG_CYC = `CTS_LONG_MS * `CLK_KHZ,
    parameter int BLINK_CYC = `BLINK_MS * `CLK_KHZ,
    parameter int CNT_W = 24,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // link side, on the line bit clock
    input wire logic link_clk,
    input wire logic terminal_tx_data,
    input wire logic line_rx_data,
    output logic line_tx_data,
    output logic terminal_rx_data,
    // terminal control lines
    input wire logic terminal_rts,
    input wire logic terminal_analog_loop_req,
    input wire logic terminal_remote_loop_req,
    output logic terminal_cts,
    // front panel
    input wire logic panel_analog_btn,
    input wire logic panel_digital_btn,
    input wire logic panel_remote_btn,
    input wire logic panel_pattern_btn,
    output logic error_led,
    output logic test_led,
    // line front end
    input wire logic line_energy_present,
    input wire logic line_energy_strong,
    output logic carrier_detect,
    output logic carrier_enable,
    output logic line_tx_enable,
    output logic remote_loop_request,
    // clocking
    output logic [1:0] tx_clock_source_sel,
    output logic internal_bit_clk
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [`NCO_W-1:0] nco_step(input logic [2:0] sel);
        logic [63:0] kbps;
        kbps = 64'd0;
        unique case (sel)
            3'h0: kbps = 64'd`RATE_0;
            3'h1: kbps = 64'd`RATE_1;
            3'h2: kbps = 64'd`RATE_2;
            3'h3: kbps = 64'd`RATE_3;
            3'h4: kbps = 64'd`RATE_4;
            3'h5: kbps = 64'd`RATE_5;
            3'h6: kbps = 64'd`RATE_6;
            3'h7: kbps = 64'd`RATE_7;
        endcase
        nco_step = `NCO_W'((kbps << `NCO_W) / 64'd`CLK_KHZ);
    endfunction

    // bus and register group
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, ctrl_reg, ctrl_next, wmask, status;
    logic [3:0] wstrb_reg, wstrb_next;
    logic err_reg, err_next;
    logic [15:0] errcnt_reg, errcnt_next;
    logic aw_take, w_take, ar_take, wr_fire, err_clr;
    logic [7:0] waddr_w, raddr_w;

    // pins and control group
    logic [8:0] pin_meta_reg, pin_sync_reg;
    logic [3:0] btn_prev_reg, btn_prev_next, panel_reg, panel_next;
    logic e_meta_reg, e_sync_reg, e_prev_reg, e_prev_next, s_meta_reg, s_sync_reg;
    logic rts_s, tana_s, trem_s, cdp_s, cds_s, err_evt;
    logic ana_reg, ana_next, dig_reg, dig_next, rem_reg, rem_next, pat_reg, pat_next;
    cts_state_e cts_state_reg, cts_state_next;
    logic [CNT_W-1:0] cts_cnt_reg, cts_cnt_next, blink_cnt_reg, blink_cnt_next;
    logic cts_reg, cts_next, car_reg, car_next, txen_reg, txen_next, cd_reg, cd_next;
    logic blink_reg, blink_next, led_reg, led_next, test_reg, test_next, rreq_reg, rreq_next;
    logic [1:0] clksel_reg, clksel_next;
    logic [`NCO_W-1:0] nco_reg, nco_next;
    logic ibc_reg, ibc_next;
    logic link_sync, link_tog;

    assign aw_take = s_axi_awvalid && awready_reg;
    assign w_take = s_axi_wvalid && wready_reg;
    assign ar_take = s_axi_arvalid && arready_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign waddr_w = {waddr_reg[7:2], 2'b00};
    assign raddr_w = {s_axi_araddr[7:2], 2'b00};
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign err_clr = wr_fire && waddr_w == `OFF_STATUS && wstrb_reg[0] && wdata_reg[`STAT_ERR];
    assign {cds_s, cdp_s, trem_s, tana_s, rts_s} = pin_sync_reg[4:0];
    assign err_evt = e_sync_reg ^ e_prev_reg;

    always_comb begin
        status = 32'h0;
        status[`STAT_ERR] = err_reg;
        status[`STAT_SYNC] = s_sync_reg;
        status[`STAT_ANALOG] = ana_reg;
        status[`STAT_DIGITAL] = dig_reg;
        status[`STAT_REMOTE] = rem_reg;
        status[`STAT_PATTERN] = pat_reg;
        status[`STAT_CTS] = cts_reg;
        status[`STAT_CD] = cd_reg;
        status[`STAT_CARRIER] = car_reg;
    end

    always_comb begin
        aw_have_next = (aw_have_reg || aw_take) && !wr_fire;
        w_have_next = (w_have_reg || w_take) && !wr_fire;
        waddr_next = aw_take ? s_axi_awaddr : waddr_reg;
        wdata_next = w_take ? s_axi_wdata : wdata_reg;
        wstrb_next = w_take ? s_axi_wstrb : wstrb_reg;
        bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        if (wr_fire) begin
            bresp_next = RESP_OKAY;
            if (waddr_w == `OFF_CTRL) begin
                ctrl_next = ((ctrl_reg & ~wmask) | (wdata_reg & wmask)) & `CTRL_MASK;
            end else if (waddr_w != `OFF_STATUS && waddr_w != `OFF_ERRCNT) begin
                bresp_next = RESP_SLVERR;
            end
        end
        // a new error in the clearing cycle survives the clear
        err_next = err_evt || (err_reg && !err_clr);
        if (err_evt) begin
            errcnt_next = err_clr ? 16'h0001 : ((errcnt_reg == 16'hffff) ? errcnt_reg : errcnt_reg + 16'h0001);
        end else begin
            errcnt_next = err_clr ? 16'h0000 : errcnt_reg;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
        rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
        arready_next = !rvalid_next;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (ar_take) begin
            rresp_next = RESP_OKAY;
            unique case (raddr_w)
                `OFF_CTRL: rdata_next = ctrl_reg;
                `OFF_STATUS: rdata_next = status;
                `OFF_ERRCNT: rdata_next = {16'h0000, errcnt_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rresp_reg <= 2'h0;
            waddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            rdata_reg <= 32'h0;
            ctrl_reg <= `CTRL_RESET;
            err_reg <= 1'b0;
            errcnt_reg <= 16'h0000;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            err_reg <= err_next;
            errcnt_reg <= errcnt_next;
        end
    end

    always_comb begin
        btn_prev_next = pin_sync_reg[8:5];
        // buttons toggle a loop; disabling the panel drops panel loops
        panel_next = ctrl_reg[`CTRL_PANEL_EN] ? (panel_reg ^ (pin_sync_reg[8:5] & ~btn_prev_reg)) : 4'h0;
        ana_next = panel_reg[0] || (ctrl_reg[`CTRL_ANALOG_EN] && tana_s);
        dig_next = panel_reg[1];
        rem_next = panel_reg[2] || (ctrl_reg[`CTRL_REMOTE_EN] && trem_s);
        pat_next = ctrl_reg[`CTRL_PATTERN] || panel_reg[3];
        rreq_next = rem_next;
        test_next = ana_next || dig_next || rem_next || pat_next;
        e_prev_next = e_sync_reg;
        cts_state_next = cts_state_reg;
        cts_cnt_next = cts_cnt_reg;
        unique case (cts_state_reg)
            CTS_OFF: if (rts_s) begin
                cts_state_next = CTS_WAIT;
                cts_cnt_next = ctrl_reg[`CTRL_CTS_LONG] ? CNT_W'(CTS_LONG_CYC - 1) : CNT_W'(CTS_SHORT_CYC - 1);
            end
            CTS_WAIT: if (!rts_s) begin
                cts_state_next = CTS_OFF;
            end else if (cts_cnt_reg == '0) begin
                cts_state_next = CTS_ON;
            end else begin
                cts_cnt_next = cts_cnt_reg - CNT_W'(1);
            end
            CTS_ON: if (!rts_s) begin
                cts_state_next = CTS_OFF;
            end
        endcase
        cts_next = cts_state_next == CTS_ON;
        car_next = ctrl_reg[`CTRL_CARRIER_OPT] || rts_s;
        // half duplex keys the line driver from rts so both ends can share it
        txen_next = ctrl_reg[`CTRL_HALF_DUPLEX] ? rts_s : car_next;
        cd_next = ctrl_reg[`CTRL_CD_HIGH] ? cdp_s : cds_s;
        if (blink_cnt_reg == '0) begin
            blink_cnt_next = CNT_W'(BLINK_CYC - 1);
            blink_next = ~blink_reg;
        end else begin
            blink_cnt_next = blink_cnt_reg - CNT_W'(1);
            blink_next = blink_reg;
        end
        led_next = err_reg && (ctrl_reg[`CTRL_BLINK] ? blink_reg : 1'b1);
        clksel_next = (ctrl_reg[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB] == CLK_TERMINAL) ? CLK_TERMINAL :
            (ctrl_reg[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB] == CLK_RECOVERED) ? CLK_RECOVERED : CLK_INTERNAL;
        nco_next = nco_reg + nco_step(ctrl_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
        ibc_next = nco_next[`NCO_W-1];
    end

    always_ff @(posedge aclk) begin
        pin_meta_reg <= {panel_pattern_btn, panel_remote_btn, panel_digital_btn, panel_analog_btn,
            line_energy_strong, line_energy_present, terminal_remote_loop_req, terminal_analog_loop_req, terminal_rts};
        pin_sync_reg <= pin_meta_reg;
        e_meta_reg <= link_tog;
        e_sync_reg <= e_meta_reg;
        s_meta_reg <= link_sync;
        s_sync_reg <= s_meta_reg;
        if (!aresetn) begin
            btn_prev_reg <= 4'h0;
            panel_reg <= 4'h0;
            e_prev_reg <= 1'b0;
            ana_reg <= 1'b0;
            dig_reg <= 1'b0;
            rem_reg <= 1'b0;
            pat_reg <= 1'b0;
            rreq_reg <= 1'b0;
            test_reg <= 1'b0;
            cts_state_reg <= CTS_OFF;
            cts_cnt_reg <= '0;
            cts_reg <= 1'b0;
            car_reg <= 1'b0;
            txen_reg <= 1'b0;
            cd_reg <= 1'b0;
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            led_reg <= 1'b0;
            clksel_reg <= CLK_INTERNAL;
            nco_reg <= '0;
            ibc_reg <= 1'b0;
        end else begin
            btn_prev_reg <= btn_prev_next;
            panel_reg <= panel_next;
            e_prev_reg <= e_prev_next;
            ana_reg <= ana_next;
            dig_reg <= dig_next;
            rem_reg <= rem_next;
            pat_reg <= pat_next;
            rreq_reg <= rreq_next;
            test_reg <= test_next;
            cts_state_reg <= cts_state_next;
            cts_cnt_reg <= cts_cnt_next;
            cts_reg <= cts_next;
            car_reg <= car_next;
            txen_reg <= txen_next;
            cd_reg <= cd_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            led_reg <= led_next;
            clksel_reg <= clksel_next;
            nco_reg <= nco_next;
            ibc_reg <= ibc_next;
        end
    end

    prbs9_link link_u (
        .link_clk(link_clk),
        .aresetn(aresetn),
        .pattern_on(pat_reg),
        .analog_on(ana_reg),
        .digital_on(dig_reg),
        .seq_delay_on(ctrl_reg[`CTRL_SEQ_DELAY]),
        .terminal_tx_data(terminal_tx_data),
        .line_rx_data(line_rx_data),
        .line_tx_data(line_tx_data),
        .terminal_rx_data(terminal_rx_data),
        .err_toggle(link_tog),
        .in_sync(link_sync)
    );

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign terminal_cts = cts_reg;
    assign carrier_enable = car_reg;
    assign line_tx_enable = txen_reg;
    assign carrier_detect = cd_reg;
    assign error_led = led_reg;
    assign test_led = test_reg;
    assign remote_loop_request = rreq_reg;
    assign tx_clock_source_sel = clksel_reg;
    assign internal_bit_clk = ibc_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cts_wait_done;
        cts_state_reg == CTS_WAIT && cts_cnt_reg == '0 && rts_s;
    endsequence
    sequence s_rts_start;
        cts_state_reg == CTS_OFF && rts_s;
    endsequence

    a_cts_after_wait: assert property (s_cts_wait_done |=> terminal_cts)
        else $error("cts not raised after delay");
    a_cts_not_early: assert property (s_rts_start |=> !terminal_cts [*2])
        else $error("cts raised without delay");
    a_carrier_perm: assert property (ctrl_reg[`CTRL_CARRIER_OPT] |=> carrier_enable)
        else $error("permanent carrier dropped");
    a_carrier_rts: assert property ((!ctrl_reg[`CTRL_CARRIER_OPT] && !rts_s) |=> !carrier_enable)
        else $error("carrier on without rts");
    a_panel_gated: assert property (!ctrl_reg[`CTRL_PANEL_EN] |=> panel_reg == 4'h0 ##1 !dig_reg)
        else $error("panel loop while disabled");
    a_remote_gate: assert property ((!ctrl_reg[`CTRL_REMOTE_EN] && panel_reg[2] == 1'b0) |=> !rem_reg)
        else $error("remote loop without enable");
    a_analog_gate: assert property ((!ctrl_reg[`CTRL_ANALOG_EN] && panel_reg[0] == 1'b0) |=> !ana_reg)
        else $error("analog loop without enable");
    a_clock_select: assert property (##1 tx_clock_source_sel != 2'h3)
        else $error("illegal clock source");
    a_cd_sense: assert property ((ctrl_reg[`CTRL_CD_HIGH] && cdp_s) |=> carrier_detect)
        else $error("carrier detect missed");
    a_err_steady: assert property ((err_reg && !ctrl_reg[`CTRL_BLINK]) |=> error_led)
        else $error("error lamp not lit");
    a_err_kept: assert property ((err_evt && err_clr) |=> err_reg)
        else $error("error lost in clear");
    a_bresp_after: assert property ($rose(s_axi_bvalid) |-> $past(aw_have_reg && w_have_reg))
        else $error("write answered early");
endmodule

// >>> far_end_model.sv
`timescale 1ns/1ps
module far_end_model (
    // link clock
    input wire logic link_clk,
    // line wires
    input wire logic line_tx_data,
    input wire logic inject,
    output logic line_rx_data
);
    // echoes the pattern back one bit late; inject flips a bit on purpose
    initial line_rx_data = 1'b1;
    always @(posedge link_clk) begin
        line_rx_data <= line_tx_data ^ inject;
    end
endmodule

// >>> line_modem_timing_and_diagnostics_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, a, b); end end
module line_modem_timing_and_diagnostics_bench;
    logic aclk = 0, link_clk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, terminal_rts = 0, inj = 0, rnd = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_tx_data, line_rx_data;
    logic terminal_cts, error_led, test_led, carrier_enable, line_tx_enable, remote_loop_request;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, m = '1, lfsr = 32'h2a1b557c;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, tx_clock_source_sel;
    logic [33:0] e;
    logic [33:0] expq[$];
    int n_mismatch = 0, n_checks = 0;
    always #12.5 aclk = ~aclk;
    always #7.5 link_clk = ~link_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    always @(posedge aclk) lfsr <= lfsr_next(lfsr);
    line_modem_core #(.CTS_SHORT_CYC(20), .CTS_LONG_CYC(40), .BLINK_CYC(8)) dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .terminal_tx_data(lfsr[9]), .line_rx_data,
        .line_tx_data, .terminal_rx_data(), .terminal_rts, .terminal_analog_loop_req(rnd & lfsr[4]),
        .terminal_remote_loop_req(rnd & lfsr[7]), .terminal_cts, .panel_analog_btn(rnd & lfsr[0]),
        .panel_digital_btn(rnd & lfsr[1]), .panel_remote_btn(rnd & lfsr[2]), .panel_pattern_btn(rnd & lfsr[3]),
        .error_led, .test_led, .line_energy_present(lfsr[5]), .line_energy_strong(lfsr[6]),
        .carrier_detect(), .carrier_enable, .line_tx_enable, .remote_loop_request, .tx_clock_source_sel,
        .internal_bit_clk());
    far_end_model far (.link_clk, .line_tx_data, .inject(inj), .line_rx_data);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        // the request just scheduled is not visible yet, so the loop body runs at least once
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 0;
                `CHK(s_axi_bresp, 2'h0)
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [33:0] x);
        expq.push_back(x);
        @(posedge aclk);
        {m, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {mk, a, 2'h3};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) s_axi_rready <= 0;
        end while (s_axi_arvalid || s_axi_rready);
    endtask
    // monitor takes the oldest note at each read answer
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = expq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata & m}, e)
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        rd(8'h00, '1, {2'h0, 32'h7e00});
        rd(8'h0c, '1, {2'h2, 32'h0});
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, i);
            repeat (2) @(posedge aclk);
            `CHK(tx_clock_source_sel, (i == 3) ? 2'h0 : i[1:0])
        end
        $display("clock select done");
        // all enables off while buttons and terminal lines chatter
        wr(8'h00, 32'h40);
        rnd <= 1;
        repeat (120) @(posedge aclk);
        rd(8'h04, 32'h3f, {2'h0, 32'h22});
        `CHK({remote_loop_request, test_led}, 2'h1)
        @(posedge link_clk) inj <= 1;
        @(posedge link_clk) inj <= 0;
        repeat (10) @(posedge aclk);
        rd(8'h04, 32'h21, {2'h0, 32'h21});
        `CHK(error_led, 1'b1)
        // one flipped bit misses on arrival and again as it passes each tap
        rd(8'h08, '1, {2'h0, 32'h3});
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h1, {2'h0, 32'h0});
        rd(8'h08, '1, {2'h0, 32'h0});
        `CHK(error_led, 1'b0)
        $display("pattern test done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, k ? 32'h140 : 32'h40);
            terminal_rts <= 1;
            repeat (30) @(posedge aclk);
            `CHK(terminal_cts, !k)
            repeat (20) @(posedge aclk);
            `CHK(terminal_cts, 1'b1)
            `CHK({carrier_enable, line_tx_enable, test_led}, 3'h7)
            terminal_rts <= 0;
            repeat (5) @(posedge aclk);
            `CHK({terminal_cts, carrier_enable, line_tx_enable}, 3'h0)
        end
        // half duplex keys the driver from rts even with the carrier held on
        wr(8'h00, 32'h260);
        repeat (3) @(posedge aclk);
        `CHK({carrier_enable, line_tx_enable}, 2'h2)
        $display("cts test done");
        final_report;
    end
    initial begin
        #300000;
        n_mismatch++;
        final_report;
    end
endmodule
